// [inc/dds_pkg.sv]
package dds_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] DDS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] DDS_OFF_STATUS = 8'h04;
   localparam logic [7:0] DDS_OFF_DIV_LO = 8'h08;
   localparam logic [7:0] DDS_OFF_DIV_HI = 8'h0c;
   localparam logic [7:0] DDS_OFF_UP_LO  = 8'h10;
   localparam logic [7:0] DDS_OFF_UP_HI  = 8'h14;
   localparam logic [7:0] DDS_OFF_LO_LO  = 8'h18;
   localparam logic [7:0] DDS_OFF_LO_HI  = 8'h1c;

   // control fields
   localparam int DDS_CTRL_START   = 0;
   localparam int DDS_CTRL_KEEP    = 1;
   localparam int DDS_CTRL_ACC_NEG = 2;
   localparam int DDS_CTRL_DIV_NEG = 3;

   // status fields
   localparam int DDS_ST_BUSY    = 0;
   localparam int DDS_ST_END     = 1;
   localparam int DDS_ST_REM_CTL = 2;
   localparam int DDS_ST_REM_NEG = 3;
   localparam int DDS_ST_QUO_NEG = 4;
   localparam int DDS_ST_QDL     = 5;
   localparam int DDS_ST_CYC_LSB = 8;

   // ****************************************
   // drum timing: digit slots within one word time
   // ****************************************
   localparam int         DDS_DIGIT_CYCLES = 4;
   localparam logic [4:0] DDS_LOW_SIGN     = 5'd0;
   localparam logic [4:0] DDS_LOW_HIGH     = 5'd10;
   localparam logic [4:0] DDS_LOW_OVF      = 5'd11;
   localparam logic [4:0] DDS_UP_SIGN      = 5'd12;
   localparam logic [4:0] DDS_UP_HIGH      = 5'd22;
   localparam logic [4:0] DDS_UP_OVF       = 5'd23;
   localparam logic [3:0] DDS_SHIFT_LAST   = 4'h9;

   localparam logic [31:0] DDS_RESET_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {DDS_IDLE, DDS_SHIFT, DDS_SUB, DDS_ADD} dds_cyc_t;
endpackage

// [design/dds_digit_timer.sv]
// ****************************************
// drum word and digit timing
// ****************************************
module dds_digit_timer
   import dds_pkg::*;
#(
   parameter int DIGIT_CYCLES = DDS_DIGIT_CYCLES
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   output logic      [4:0] digit_idx,
   output logic            digit_en,
   output logic            word_end
);
   logic [7:0] cnt_ff;
   logic [4:0] idx_ff;

   // last clock of each digit slot
   assign digit_en  = (cnt_ff == 8'(DIGIT_CYCLES - 1));
   assign word_end  = digit_en && (idx_ff == DDS_UP_OVF);
   assign digit_idx = idx_ff;

   // free-running, like the drum itself: nothing ever stops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 8'h00;
         idx_ff <= 5'h00;
      end else if (digit_en) begin
         cnt_ff <= 8'h00;
         idx_ff <= (idx_ff == DDS_UP_OVF) ? 5'h00 : idx_ff + 5'h01;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule

// [design/dds_divide_seq.sv]
// Functional notes
// - divide opens with a left shift cycle
// - shift moves dividend and quotient one digit left
// - shift count starts zero, plus one per shift
// - shift end sets complement add and true add
// - distributor zeros in lower, high and overflow digits
// - overflow-slot carry tells dividend sign change
// - quotient digit latch follows complement add at high digit
// - carry holds latches on for another reduction
// - repeated reduction adds one at lowest quotient digit
// - reduction carry at lowest quotient except first
// - overdraw drops complement add, starts correction
// - correction adds true divisor to upper once
// - correction end restarts shift unless end latch
// - tenth shift carry sets the end latch
// - final correction end clears divide latch
// - completion drops interlock for program control
// - resetting code zeroes upper on last correction
// - keeping code leaves remainder, remainder sign readout
// - remainder sign copied from dividend sign at start
module dds_divide_seq
   import dds_pkg::*;
#(
   parameter int DIGIT_CYCLES = DDS_DIGIT_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             op_interlock,
   output logic             op_end_pulse,
   output logic             sign_minus_out,
   output logic             dist_zero_entry,
   output logic             carry_ins_lowest
);
   // ****************************************
   // decimal arithmetic helpers
   // ****************************************
   function automatic logic [44:0] bcd_add(input logic [43:0] a, input logic [43:0] b,
                                           input logic cin);
      logic [4:0]  s;
      logic        c;
      logic [43:0] r;
      c = cin;
      r = 44'h0;
      for (int i = 0; i < 11; i++) begin
         s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
         c = (s > 5'd9);
         r[i*4 +: 4] = c ? 4'(s - 5'd10) : s[3:0];
      end
      return {c, r};
   endfunction

   function automatic logic [43:0] nines(input logic [43:0] a);
      logic [43:0] r;
      r = 44'h0;
      for (int i = 0; i < 11; i++) begin
         r[i*4 +: 4] = 4'h9 - a[i*4 +: 4];
      end
      return r;
   endfunction

   // ****************************************
   // state
   // ****************************************
   dds_cyc_t    cyc_ff;
   logic        pend_ff, divide_ff, end_ff, comp_add_ff, true_add_ff, dist_true_ff;
   logic        qdl_ff, add_one_ff, first_ff, keep_ff, rem_ctl_ff;
   logic        rem_neg_ff, quo_neg_ff, interlock_ff, done_ff;
   logic        sign_ff, zero_ff, ins_ff;
   logic [43:0] up_ff;
   logic [39:0] lo_ff;
   logic [3:0]  cnt_ff;
   logic [39:0] div_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff;
   logic [4:0]  digit_idx;
   logic        digit_en, word_end;

   dds_digit_timer #(
      .DIGIT_CYCLES (DIGIT_CYCLES)
   ) u_timer (
      .pclk      (pclk),
      .presetn   (presetn),
      .digit_idx (digit_idx),
      .digit_en  (digit_en),
      .word_end  (word_end)
   );

   // ****************************************
   // datapath results, used at the word boundary
   // ****************************************
   wire [44:0] sub_res   = bcd_add(up_ff, nines({4'h0, div_ff}), 1'b1);
   wire        ovf_carry = sub_res[44];
   wire [44:0] add_res   = bcd_add(up_ff, {4'h0, div_ff}, 1'b0);
   wire [44:0] lo_inc    = bcd_add({4'h0, lo_ff}, 44'h1, 1'b0);
   wire        cnt_carry = (cnt_ff == DDS_SHIFT_LAST);
   wire [43:0] up_shift  = {up_ff[39:0], lo_ff[39:36]};
   wire [39:0] lo_shift  = {lo_ff[35:0], 4'h0};
   wire        in_shift  = (cyc_ff == DDS_SHIFT);
   wire        in_sub    = (cyc_ff == DDS_SUB);
   wire        in_add    = (cyc_ff == DDS_ADD);
   wire        last_corr = in_add && word_end && end_ff;

   // ****************************************
   // apb decode
   // ****************************************
   wire        acc_phase = psel && penable && pready_ff;
   wire        wr_en     = acc_phase && pwrite && !pslverr_ff;
   wire        addr_ok   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   // data words only take bus writes while idle so a divide never sees torn operands
   wire        data_lock = interlock_ff && (paddr != DDS_OFF_CTRL) && (paddr != DDS_OFF_STATUS);
   wire        wr_bad    = pwrite && (!addr_ok || data_lock || (paddr == DDS_OFF_STATUS));
   wire        start_req = wr_en && (paddr == DDS_OFF_CTRL) && pwdata[DDS_CTRL_START]
                           && !interlock_ff;
   wire [31:0] status_w  = {22'h0, cyc_ff, 2'h0, qdl_ff, quo_neg_ff, rem_neg_ff,
                            rem_ctl_ff, end_ff, interlock_ff};
   wire [31:0] rdata_mux =
      (paddr == DDS_OFF_CTRL)   ? {30'h0, keep_ff, 1'b0} :
      (paddr == DDS_OFF_STATUS) ? status_w :
      (paddr == DDS_OFF_DIV_LO) ? div_ff[31:0] :
      (paddr == DDS_OFF_DIV_HI) ? {24'h0, div_ff[39:32]} :
      (paddr == DDS_OFF_UP_LO)  ? up_ff[31:0] :
      (paddr == DDS_OFF_UP_HI)  ? {20'h0, up_ff[43:32]} :
      (paddr == DDS_OFF_LO_LO)  ? lo_ff[31:0] :
      (paddr == DDS_OFF_LO_HI)  ? {20'h0, cnt_ff, lo_ff[39:32]} : DDS_RESET_WORD;

   // no wait state: answer is prepared in setup, pready high in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= DDS_RESET_WORD;
      end else begin
         pready_ff  <= psel && !penable;
         pslverr_ff <= psel && !penable && (pwrite ? wr_bad : !addr_ok);
         if (psel && !penable) begin
            prdata_ff <= pwrite ? DDS_RESET_WORD : rdata_mux;
         end
      end
   end

   // ****************************************
   // operand and accumulator words
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 40'h0;
         up_ff  <= 44'h0;
         lo_ff  <= 40'h0;
         cnt_ff <= 4'h0;
      // busy data-word writes are refused anyway; gating on the interlock keeps a
      // control write from swallowing a word-boundary datapath step
      end else if (wr_en && !interlock_ff) begin
         case (paddr)
            DDS_OFF_DIV_LO: div_ff[31:0]  <= pwdata;
            DDS_OFF_DIV_HI: div_ff[39:32] <= pwdata[7:0];
            DDS_OFF_UP_LO:  up_ff[31:0]   <= pwdata;
            DDS_OFF_UP_HI:  up_ff[43:32]  <= pwdata[11:0];
            DDS_OFF_LO_LO:  lo_ff[31:0]   <= pwdata;
            DDS_OFF_LO_HI:  lo_ff[39:32]  <= pwdata[7:0];
            DDS_OFF_CTRL:   cnt_ff        <= start_req ? 4'h0 : cnt_ff;
            default:        cnt_ff        <= cnt_ff;
         endcase
      end else if (word_end) begin
         case (cyc_ff)
            DDS_SHIFT: begin
               up_ff  <= up_shift;
               lo_ff  <= lo_shift;
               cnt_ff <= cnt_carry ? 4'h0 : cnt_ff + 4'h1;
            end
            DDS_SUB: begin
               up_ff <= sub_res[43:0];
               if (add_one_ff) begin
                  lo_ff <= lo_inc[39:0];
               end
            end
            DDS_ADD: begin
               up_ff <= (end_ff && !keep_ff) ? 44'h0 : add_res[43:0];
            end
            default: begin
               up_ff <= up_ff;
            end
         endcase
      end
   end

   // ****************************************
   // cycle sequencer, stepped only at word boundaries
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_ff       <= DDS_IDLE;
         pend_ff      <= 1'b0;
         divide_ff    <= 1'b0;
         end_ff       <= 1'b0;
         comp_add_ff  <= 1'b0;
         true_add_ff  <= 1'b0;
         dist_true_ff <= 1'b0;
         add_one_ff   <= 1'b0;
         first_ff     <= 1'b0;
         done_ff      <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start_req) begin
            pend_ff   <= 1'b1;
            divide_ff <= 1'b1;
            end_ff    <= 1'b0;
         end else if (word_end) begin
            case (cyc_ff)
               DDS_IDLE: begin
                  if (pend_ff) begin
                     pend_ff <= 1'b0;
                     cyc_ff  <= DDS_SHIFT;
                  end
               end
               DDS_SHIFT: begin
                  end_ff      <= end_ff || cnt_carry;
                  comp_add_ff <= 1'b1;
                  true_add_ff <= 1'b1;
                  first_ff    <= 1'b1;
                  add_one_ff  <= 1'b0;
                  cyc_ff      <= DDS_SUB;
               end
               DDS_SUB: begin
                  first_ff   <= 1'b0;
                  add_one_ff <= ovf_carry && qdl_ff;
                  if (ovf_carry && qdl_ff) begin
                     cyc_ff <= DDS_SUB;
                  end else begin
                     comp_add_ff  <= 1'b0;
                     dist_true_ff <= 1'b1;
                     cyc_ff       <= DDS_ADD;
                  end
               end
               DDS_ADD: begin
                  true_add_ff  <= 1'b0;
                  dist_true_ff <= 1'b0;
                  if (divide_ff && !qdl_ff && end_ff) begin
                     divide_ff <= 1'b0;
                     done_ff   <= 1'b1;
                     cyc_ff    <= DDS_IDLE;
                  end else if (divide_ff && !qdl_ff) begin
                     cyc_ff <= DDS_SHIFT;
                  end else begin
                     cyc_ff <= DDS_IDLE;
                  end
               end
               default: cyc_ff <= DDS_IDLE;
            endcase
         end
      end
   end

   // quotient digit latch sampled at upper high digit time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qdl_ff <= 1'b0;
      end else if (digit_en && digit_idx == DDS_UP_HIGH) begin
         qdl_ff <= comp_add_ff;
      end
   end

   // ****************************************
   // signs, remainder control, interlock
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keep_ff      <= 1'b0;
         rem_ctl_ff   <= 1'b0;
         rem_neg_ff   <= 1'b0;
         quo_neg_ff   <= 1'b0;
         interlock_ff <= 1'b0;
      end else if (start_req) begin
         keep_ff      <= pwdata[DDS_CTRL_KEEP];
         rem_ctl_ff   <= 1'b0;
         rem_neg_ff   <= pwdata[DDS_CTRL_ACC_NEG];
         quo_neg_ff   <= pwdata[DDS_CTRL_ACC_NEG] ^ pwdata[DDS_CTRL_DIV_NEG];
         interlock_ff <= 1'b1;
      end else if (last_corr && !qdl_ff) begin
         rem_ctl_ff   <= keep_ff;
         interlock_ff <= 1'b0;
      end
   end

   // ****************************************
   // digit-timed control outputs
   // ****************************************
   // registered from the current slot, so they trail the slot by one clock
   wire zero_slot = (digit_idx <= DDS_LOW_OVF) || (digit_idx == DDS_UP_HIGH)
                    || (digit_idx == DDS_UP_OVF);
   wire rem_slot  = (digit_idx == DDS_UP_SIGN) && rem_ctl_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_ff <= 1'b0;
         ins_ff  <= 1'b0;
         sign_ff <= 1'b0;
      end else begin
         zero_ff <= in_sub && zero_slot;
         ins_ff  <= in_sub && comp_add_ff && !first_ff;
         sign_ff <= rem_slot ? rem_neg_ff : quo_neg_ff;
      end
   end

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign op_interlock     = interlock_ff;
   assign op_end_pulse     = done_ff;
   assign sign_minus_out   = sign_ff;
   assign dist_zero_entry  = zero_ff;
   assign carry_ins_lowest = ins_ff;

   // ****************************************
   // checks
   // ****************************************
   property p_first_shift;
      @(posedge pclk) disable iff (!presetn)
      (cyc_ff == DDS_IDLE) && pend_ff && word_end |=> (cyc_ff == DDS_SHIFT);
   endproperty
   a_first_shift: assert property (p_first_shift) else $error("divide did not open with shift");

   property p_count;
      @(posedge pclk) disable iff (!presetn)
      in_shift && word_end && !cnt_carry && !wr_en |=> cnt_ff == $past(cnt_ff) + 4'h1;
   endproperty
   a_count: assert property (p_count) else $error("shift count not advanced");

   property p_sub_setup;
      @(posedge pclk) disable iff (!presetn)
      in_shift && word_end |=> comp_add_ff && true_add_ff && (cyc_ff == DDS_SUB);
   endproperty
   a_sub_setup: assert property (p_sub_setup) else $error("subtract not set up");

   property p_qdl;
      @(posedge pclk) disable iff (!presetn)
      digit_en && (digit_idx == DDS_UP_HIGH) |=> qdl_ff == $past(comp_add_ff);
   endproperty
   a_qdl: assert property (p_qdl) else $error("quotient digit latch wrong");

   property p_again;
      @(posedge pclk) disable iff (!presetn)
      in_sub && word_end && ovf_carry && qdl_ff && !start_req |=> in_sub && comp_add_ff;
   endproperty
   a_again: assert property (p_again) else $error("carry did not repeat reduction");

   property p_overdraw;
      @(posedge pclk) disable iff (!presetn)
      in_sub && word_end && !ovf_carry |=> in_add && dist_true_ff && true_add_ff && !comp_add_ff;
   endproperty
   a_overdraw: assert property (p_overdraw) else $error("overdraw did not correct");

   property p_end_latch;
      @(posedge pclk) disable iff (!presetn)
      in_shift && word_end && cnt_carry |=> end_ff;
   endproperty
   a_end_latch: assert property (p_end_latch) else $error("tenth shift missed end");

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      last_corr && divide_ff && !qdl_ff |=> !divide_ff && done_ff && !interlock_ff ##1 !done_ff;
   endproperty
   a_stop: assert property (p_stop) else $error("divide did not stop");

   property p_rem_reset;
      @(posedge pclk) disable iff (!presetn)
      last_corr && !keep_ff && !wr_en |=> up_ff == 44'h0;
   endproperty
   a_rem_reset: assert property (p_rem_reset) else $error("remainder not cleared");

   property p_word_step;
      @(posedge pclk) disable iff (!presetn)
      (cyc_ff != $past(cyc_ff)) |-> $past(word_end);
   endproperty
   a_word_step: assert property (p_word_step) else $error("cycle changed inside a word");
endmodule

// [tb/dds_prog_ctl.sv]
// ****************************************
// program control partner: waits on the interlock, steps the commutator
// ****************************************
module dds_prog_ctl
   import dds_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       op_interlock,
   input  wire logic       op_end_pulse,
   output logic      [7:0] step_cnt,
   output logic      [7:0] end_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic lock_ff;

   // commutator only advances once the interlock has dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_ff  <= 1'b0;
         step_cnt <= 8'h00;
         end_cnt  <= 8'h00;
      end else begin
         lock_ff <= op_interlock;
         if (lock_ff && !op_interlock) begin
            step_cnt <= step_cnt + 8'h01;
         end
         if (op_end_pulse === 1'b1) begin
            end_cnt <= end_cnt + 8'h01;
         end
      end
   end
endmodule

// [tb/tb_top.sv]
module tb_top
   import dds_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, op_interlock, op_end_pulse;
   logic        sign_minus_out, dist_zero_entry, carry_ins_lowest;
   logic [7:0]  step_cnt, end_cnt;
   int          err_total, samples_checked, cyc, dz_cnt, ins_cnt, sg_cnt;

   // one clock per digit slot makes a word 24 clocks, so a divide here takes roughly 800 to 2500 clocks
   dds_divide_seq #(.DIGIT_CYCLES(1)) u_dds_divide_seq (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_interlock(op_interlock),
      .op_end_pulse(op_end_pulse), .sign_minus_out(sign_minus_out),
      .dist_zero_entry(dist_zero_entry), .carry_ins_lowest(carry_ins_lowest));

   dds_prog_ctl u_dds_prog_ctl (
      .pclk(pclk), .presetn(presetn), .op_interlock(op_interlock),
      .op_end_pulse(op_end_pulse), .step_cnt(step_cnt), .end_cnt(end_cnt));

   // ****************************************
   // clock, watchdog and slot counters
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (dist_zero_entry === 1'b1) dz_cnt = dz_cnt + 1;
      if (carry_ins_lowest === 1'b1) ins_cnt = ins_cnt + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         report_and_stop();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // request held from setup until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("counts: %0d checked, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      apb(1'b0, DDS_OFF_STATUS, 32'h0, q, e);
      check("status after reset", q, DDS_RESET_WORD);
      apb(1'b0, DDS_OFF_UP_LO, 32'h0, q, e);
      check("upper after reset", q, DDS_RESET_WORD);
      apb(1'b0, 8'h20, 32'h0, q, e);
      check("unmapped err", {31'h0, e}, 32'h1);
      check("unmapped data", q, 32'h0);
      apb(1'b0, 8'h02, 32'h0, q, e);
      check("unaligned err", {31'h0, e}, 32'h1);
      apb(1'b1, DDS_OFF_STATUS, 32'hffff_ffff, q, e);
      check("status write err", {31'h0, e}, 32'h1);
      $display("test regs done");
   endtask

   // loads operands, starts, watches the cycle order, judges the results
   task automatic run_div(input logic keep, input logic an, input logic dn,
                          input logic [31:0] up, input logic [31:0] lo,
                          input logic [31:0] dv, input logic [31:0] qlo,
                          input logic [31:0] qhi, input logic [31:0] rem,
                          input int dz_exp, input logic poke);
      logic [31:0] q;
      logic        e;
      int          n;
      logic [7:0]  st0;
      st0 = step_cnt;
      apb(1'b1, DDS_OFF_DIV_LO, dv, q, e);
      apb(1'b1, DDS_OFF_DIV_HI, 32'h0, q, e);
      apb(1'b1, DDS_OFF_UP_LO, up, q, e);
      apb(1'b1, DDS_OFF_UP_HI, 32'h0, q, e);
      apb(1'b1, DDS_OFF_LO_LO, lo, q, e);
      apb(1'b1, DDS_OFF_LO_HI, 32'h0, q, e);
      dz_cnt  = 0;
      ins_cnt = 0;
      apb(1'b1, DDS_OFF_CTRL, {28'h0, dn, an, keep, 1'b1}, q, e);
      n = 0;
      do begin
         apb(1'b0, DDS_OFF_STATUS, 32'h0, q, e);
         n = n + 1;
      end while (q[9:8] === 2'd0 && n < 100);
      check("first cycle", {30'h0, q[9:8]}, 32'h1);
      check("busy", {31'h0, q[DDS_ST_BUSY]}, 32'h1);
      check("quotient sign", {31'h0, q[DDS_ST_QUO_NEG]}, {31'h0, an ^ dn});
      check("rem sign", {31'h0, q[DDS_ST_REM_NEG]}, {31'h0, an});
      do begin
         apb(1'b0, DDS_OFF_STATUS, 32'h0, q, e);
         n = n + 1;
      end while (q[9:8] === 2'd1 && n < 200);
      check("after shift", {30'h0, q[9:8]}, 32'h2);
      if (poke) begin
         apb(1'b1, DDS_OFF_CTRL, 32'h1, q, e);
         check("restart ignored", {31'h0, e}, 32'h0);
         apb(1'b1, DDS_OFF_UP_LO, 32'h7, q, e);
         check("busy write err", {31'h0, e}, 32'h1);
      end
      n = 0;
      while (op_interlock === 1'b1 && n < 5000) begin
         @(posedge pclk);
         n = n + 1;
      end
      repeat (3) @(posedge pclk);
      check("commutator steps", {24'h0, step_cnt}, {24'h0, st0 + 8'h01});
      check("end pulses", {24'h0, end_cnt}, {24'h0, st0 + 8'h01});
      check("zero entry clocks", dz_cnt, dz_exp);
      // every reduction but the first after each of the ten shifts, one word each
      check("carry insert clocks", ins_cnt, (dz_exp / 14 - 10) * 24);
      // one full word of sign readout: remainder sign only at the upper sign slot
      sg_cnt = 0;
      repeat (24) begin
         @(posedge pclk);
         if (sign_minus_out === 1'b1) sg_cnt = sg_cnt + 1;
      end
      check("sign readout clocks", sg_cnt,
            keep ? (int'(an) + 23 * int'(an ^ dn)) : 24 * int'(an ^ dn));
      apb(1'b0, DDS_OFF_LO_LO, 32'h0, q, e);
      check("quotient low", q, qlo);
      apb(1'b0, DDS_OFF_LO_HI, 32'h0, q, e);
      check("quotient high", {20'h0, q[11:0]}, qhi);
      apb(1'b0, DDS_OFF_UP_LO, 32'h0, q, e);
      check("remainder", q, keep ? rem : 32'h0);
      apb(1'b0, DDS_OFF_STATUS, 32'h0, q, e);
      check("rem control", {31'h0, q[DDS_ST_REM_CTL]}, {31'h0, keep});
      check("idle", {31'h0, q[DDS_ST_BUSY]}, 32'h0);
      $display("test divide done");
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      err_total       = 0;
      samples_checked = 0;
      cyc             = 0;
      dz_cnt          = 0;
      ins_cnt         = 0;
      sg_cnt          = 0;
      presetn         = 1'b0;
      psel            = 1'b0;
      penable         = 1'b0;
      pwrite          = 1'b0;
      paddr           = 8'h00;
      pwdata          = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      // 1445 / 12: quotient 120 remainder 5, thirteen reductions
      run_div(1'b1, 1'b1, 1'b0, 32'h0, 32'h1445, 32'h12, 32'h120, 32'h0, 32'h5,
              13 * 14, 1'b0);
      // eight nines of ten reductions each plus two zero digits: 82 reductions
      run_div(1'b0, 1'b0, 1'b1, 32'h0, 32'h9999_9999, 32'h1, 32'h9999_9999, 32'h0,
              32'h0, 82 * 14, 1'b0);
      // 10^10 / 3 with a restart and a data write landing mid-run
      run_div(1'b1, 1'b0, 1'b1, 32'h1, 32'h0, 32'h3, 32'h3333_3333, 32'h33, 32'h1,
              40 * 14, 1'b1);
      report_and_stop();
   end
endmodule
